/* pkg/cfe_map.vh */
// Register map, reset values and timing counts of the channel error counter.
`ifndef CFE_MAP_VH
`define CFE_MAP_VH

// Register byte offsets on the AXI4-Lite slave.
`define CFE_OFS_CTRL      4'h0
`define CFE_OFS_THRESH    4'h4
`define CFE_OFS_STATUS    4'h8
`define CFE_OFS_CMD       4'hc

// Control register: bit 0 selects audio tone mode, which blanks the readout and on entry clears the error count and fault; no count source is switched.
`define CFE_CTRL_SRC_BIT  0
`define CFE_CTRL_RESET    1'b0
`define CFE_THRESH_RESET  12'h000

// Status register field positions.
`define CFE_ST_ERR_MSB    11
`define CFE_ST_SIGN_BIT   12
`define CFE_ST_BLANK_BIT  13
`define CFE_ST_FAULT_BIT  14
`define CFE_ST_LOW_BIT    15
`define CFE_ST_ZERO_BIT   16

// Bus responses.
`define CFE_RESP_OKAY     2'b00
`define CFE_RESP_SLVERR   2'b10

// Timing: clock period and printed times in ns, then derived cycle counts.
`define CFE_CLK_NS        5
`define CFE_RELOAD_NS     500000
`define CFE_PREBLANK_NS   2500000
`define CFE_RELOAD_CYC    (`CFE_RELOAD_NS / `CFE_CLK_NS)
`define CFE_PREBLANK_CYC  (`CFE_PREBLANK_NS / `CFE_CLK_NS)

// Transmitter prescale ratio, auxiliary oscillator period, sign one-shot.
`define CFE_PRESCALE_MAX  4'h9
`define CFE_AUX_MAX       5'h13
`define CFE_SIGN_MAX      7'h3b

`endif

/* rtl/cfe_channel_freq_error.v */
// Channel frequency error counter with AXI4-Lite register slave.
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "cfe_map.vh"

module cfe_channel_freq_error #(
    parameter [31:0] RELOAD_CYC = `CFE_RELOAD_CYC,
    parameter [31:0] PRE_CYC    = `CFE_PREBLANK_CYC
) (
    input  wire        mclk,
    input  wire        rst,
    input  wire        window_in,
    input  wire        tx_pulse_in,
    input  wire        msd_zero_in,
    input  wire [23:0] cmd_bcd,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [11:0] err_count,
    output reg         err_negative,
    output reg         readout_blank,
    output reg         freq_error_fault
);

    localparam [25:0] RELOAD_LAST = RELOAD_CYC[25:0] - 26'h1;
    localparam [25:0] PRE_LEN     = PRE_CYC[25:0];

    // Decrement a six digit BCD value by one.
    function [23:0] bcd_dec;
        input [23:0] v;
        integer      i;
        reg          borrow;
        begin
            bcd_dec = v;
            borrow = 1'b1;
            for (i = 0; i < 6; i = i + 1) begin
                if (borrow) begin
                    if (v[i*4 +: 4] == 4'h0) begin
                        bcd_dec[i*4 +: 4] = 4'h9;
                    end else begin
                        bcd_dec[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
                        borrow = 1'b0;
                    end
                end
            end
        end
    endfunction

    // Increment a three digit BCD value by one; the caller saturates at 999.
    function [11:0] bcd_inc;
        input [11:0] v;
        integer      i;
        reg          carry;
        begin
            bcd_inc = v;
            carry = 1'b1;
            for (i = 0; i < 3; i = i + 1) begin
                if (carry) begin
                    if (v[i*4 +: 4] == 4'h9) begin
                        bcd_inc[i*4 +: 4] = 4'h0;
                    end else begin
                        bcd_inc[i*4 +: 4] = v[i*4 +: 4] + 4'h1;
                        carry = 1'b0;
                    end
                end
            end
        end
    endfunction

    reg        win_s1, win_s2, win_s3;
    reg        tx_s1, tx_s2, tx_s3;
    reg        msd_s1, msd_s2;
    reg [3:0]  prescale;
    reg        tx_div;
    reg [23:0] downcount;
    reg        zero_seen;
    reg        low_side_flag;
    reg [4:0]  aux_pulse_oscillator;
    reg [6:0]  sign_oneshot;
    reg        reload_pending;
    reg [25:0] reload_cnt;
    reg [25:0] hi_cnt;
    reg [25:0] last_len;
    reg        blank_d;
    reg        fault_flag;
    reg        count_source_select;
    reg [11:0] threshold;

    wire win_rise = win_s2 & ~win_s3;
    wire win_fall = ~win_s2 & win_s3;
    wire tx_qual_n = ~(win_s2 & tx_div);
    wire tx_qual = ~tx_qual_n;
    wire aux_run = low_side_flag & ~zero_seen;
    wire aux_pulse = aux_run & (aux_pulse_oscillator == `CFE_AUX_MAX);
    wire reload = reload_pending & (reload_cnt == RELOAD_LAST);
    wire pre_blank = win_s3 & (last_len > PRE_LEN)
                   & (hi_cnt >= last_len - PRE_LEN);
    wire blank_now = pre_blank | reload_pending | count_source_select;
    wire blank_start = blank_now & ~blank_d;
    wire err_step = (zero_seen & tx_qual) | aux_pulse;
    wire [11:0] err_inc = bcd_inc(err_count);
    // Fault fires on the step reaching the threshold, not on a standing count.
    wire err_hit = err_step & ~msd_s2 & (threshold != 12'h000)
                 & (blank_start ? (threshold == 12'h001)
                    : ((err_count != 12'h999) & (err_inc == threshold)));

    // Two-stage synchronisers; the third window and pulse stages serve edges.
    always @(posedge mclk) begin
        if (rst) begin
            {win_s1, win_s2, win_s3} <= 3'h0;
            {tx_s1, tx_s2, tx_s3} <= 3'h0;
            {msd_s1, msd_s2} <= 2'h0;
        end else begin
            win_s1 <= window_in;
            win_s2 <= win_s1;
            win_s3 <= win_s2;
            tx_s1 <= tx_pulse_in;
            tx_s2 <= tx_s1;
            tx_s3 <= tx_s2;
            msd_s1 <= msd_zero_in;
            msd_s2 <= msd_s1;
        end
    end

    // Divide transmitter edges by ten before gating.
    always @(posedge mclk) begin
        if (rst) begin
            prescale <= 4'h0;
            tx_div <= 1'b0;
        end else begin
            tx_div <= 1'b0;
            if (tx_s2 & ~tx_s3) begin
                if (prescale == `CFE_PRESCALE_MAX) begin
                    prescale <= 4'h0;
                    tx_div <= 1'b1;
                end else begin
                    prescale <= prescale + 4'h1;
                end
            end
        end
    end

    // Programmable down-counter and its zero indication.
    // The zero flag is registered, so the transmitter pulse that lands on zero sees
    // zero_seen still low and is kept out of the error count.
    always @(posedge mclk) begin
        if (rst) begin
            downcount <= 24'h000000;
            zero_seen <= 1'b0;
        end else if (reload) begin
            downcount <= cmd_bcd;
            zero_seen <= (cmd_bcd == 24'h000000);
        end else if (~zero_seen & (tx_qual | aux_pulse)) begin
            downcount <= bcd_dec(downcount);
            zero_seen <= (bcd_dec(downcount) == 24'h000000);
        end
    end

    // Low-side flag and auxiliary oscillator.
    always @(posedge mclk) begin
        if (rst) begin
            low_side_flag <= 1'b0;
            aux_pulse_oscillator <= 5'h00;
        end else begin
            if (reload) begin
                low_side_flag <= 1'b0;
            end else if (win_fall & ~zero_seen) begin
                low_side_flag <= 1'b1;
            end
            if (~aux_run | aux_pulse) begin
                aux_pulse_oscillator <= 5'h00;
            end else begin
                aux_pulse_oscillator <= aux_pulse_oscillator + 5'h01;
            end
        end
    end

    // Sign one-shot, retriggered by each auxiliary pulse with window closed.
    always @(posedge mclk) begin
        if (rst) begin
            sign_oneshot <= 7'h00;
        end else if (aux_pulse & low_side_flag & ~win_s2) begin
            sign_oneshot <= `CFE_SIGN_MAX;
        end else if (sign_oneshot != 7'h00) begin
            sign_oneshot <= sign_oneshot - 7'h01;
        end
    end

    // Reload delay after window fall, and window length measurement.
    // Blanking ahead of the fall is predicted from the previous window,
    // so the first window after reset gets no early blanking.
    always @(posedge mclk) begin
        if (rst) begin
            {reload_pending, reload_cnt} <= 27'h0;
            {hi_cnt, last_len} <= 52'h0;
        end else begin
            if (win_fall) begin
                reload_pending <= 1'b1;
                reload_cnt <= 26'h0;
                last_len <= hi_cnt;
            end else if (reload) begin
                reload_pending <= 1'b0;
            end else if (reload_pending) begin
                reload_cnt <= reload_cnt + 26'h1;
            end
            if (win_rise) begin
                hi_cnt <= 26'h0;
            end else if (win_s2 & (hi_cnt != 26'h3ffffff)) begin
                hi_cnt <= hi_cnt + 26'h1;
            end
        end
    end

    // Error counter and fault flag.
    // A new event in the clearing cycle is not lost: clear and count merge.
    always @(posedge mclk) begin
        if (rst) begin
            {blank_d, fault_flag} <= 2'h0;
            err_count <= 12'h000;
        end else begin
            blank_d <= blank_now;
            if (msd_s2) begin
                err_count <= 12'h000;
            end else if (blank_start) begin
                err_count <= err_step ? 12'h001 : 12'h000;
            end else if (err_step & (err_count != 12'h999)) begin
                err_count <= err_inc;
            end
            if (err_hit) begin
                fault_flag <= 1'b1;
            end else if (blank_start) begin
                fault_flag <= 1'b0;
            end
        end
    end

    // Readout outputs, all registered.
    always @(posedge mclk) begin
        if (rst) begin
            {err_negative, readout_blank, freq_error_fault} <= 3'h0;
        end else begin
            err_negative <= (sign_oneshot != 7'h00);
            readout_blank <= blank_now;
            freq_error_fault <= fault_flag & ~blank_now;
        end
    end

    // Write channel: address and data are taken together in one cycle.
    always @(posedge mclk) begin
        if (rst) begin
            {s_axi_awready, s_axi_wready, s_axi_bvalid} <= 3'h0;
            s_axi_bresp <= `CFE_RESP_OKAY;
            count_source_select <= `CFE_CTRL_RESET;
            threshold <= `CFE_THRESH_RESET;
        end else begin
            {s_axi_awready, s_axi_wready} <= 2'h0;
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
                & ~s_axi_bvalid) begin
                {s_axi_awready, s_axi_wready, s_axi_bvalid} <= 3'h7;
                s_axi_bresp <= `CFE_RESP_OKAY;
                case (s_axi_awaddr)
                    `CFE_OFS_CTRL: begin
                        if (s_axi_wstrb[0]) begin
                            count_source_select <=
                                s_axi_wdata[`CFE_CTRL_SRC_BIT];
                        end
                    end
                    `CFE_OFS_THRESH: begin
                        if (s_axi_wstrb[0]) begin
                            threshold[7:0] <= s_axi_wdata[7:0];
                        end
                        if (s_axi_wstrb[1]) begin
                            threshold[11:8] <= s_axi_wdata[11:8];
                        end
                    end
                    `CFE_OFS_STATUS, `CFE_OFS_CMD: begin
                        s_axi_bresp <= `CFE_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `CFE_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // Read channel: one read at a time, data registered with the answer.
    always @(posedge mclk) begin
        if (rst) begin
            {s_axi_arready, s_axi_rvalid} <= 2'h0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CFE_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid) begin
                {s_axi_arready, s_axi_rvalid} <= 2'h3;
                s_axi_rresp <= `CFE_RESP_OKAY;
                s_axi_rdata <= 32'h00000000;
                case (s_axi_araddr)
                    `CFE_OFS_CTRL: begin
                        s_axi_rdata[`CFE_CTRL_SRC_BIT] <=
                            count_source_select;
                    end
                    `CFE_OFS_THRESH: begin
                        s_axi_rdata[11:0] <= threshold;
                    end
                    `CFE_OFS_STATUS: begin
                        s_axi_rdata[`CFE_ST_ERR_MSB:0] <= err_count;
                        s_axi_rdata[`CFE_ST_SIGN_BIT] <= err_negative;
                        s_axi_rdata[`CFE_ST_BLANK_BIT] <= readout_blank;
                        s_axi_rdata[`CFE_ST_FAULT_BIT] <= fault_flag;
                        s_axi_rdata[`CFE_ST_LOW_BIT] <= low_side_flag;
                        s_axi_rdata[`CFE_ST_ZERO_BIT] <= zero_seen;
                    end
                    `CFE_OFS_CMD: begin
                        s_axi_rdata[23:0] <= downcount;
                    end
                    default: begin
                        s_axi_rresp <= `CFE_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

endmodule // cfe_channel_freq_error

/* dv/cfe_far_model.sv */
// Far-side model: transmitter pulse train, gate window and command word.
`timescale 1ns/1ps

module cfe_far_model (
    input  wire        mclk,
    output reg         window_in,
    output reg         tx_pulse_in,
    output reg         msd_zero_in,
    output reg  [23:0] cmd_bcd
);

    // Idle levels: gate closed, no carrier pulses, first command ready.
    initial begin
        window_in   = 1'b0;
        tx_pulse_in = 1'b0;
        msd_zero_in = 1'b0;
        cmd_bcd     = 24'h000005;
    end

    // One gate of 376 cycles with 70 raw edges inside it.
    // Seventy edges keep the divide-by-ten phase the same every gate.
    task measure(input [23:0] next_cmd, input unkeyed);
        integer i;
        begin
            msd_zero_in <= unkeyed;
            window_in <= 1'b1;
            repeat (60) @(posedge mclk);
            for (i = 0; i < 70; i++) begin
                tx_pulse_in <= 1'b1;
                repeat (2) @(posedge mclk);
                tx_pulse_in <= 1'b0;
                repeat (2) @(posedge mclk);
            end
            repeat (36) @(posedge mclk);
            window_in <= 1'b0;
            cmd_bcd <= next_cmd;
        end
    endtask

endmodule // cfe_far_model

/* dv/cfe_channel_freq_error_properties.sv */
// Concurrent checks on the ports of the channel error counter.
`timescale 1ns/1ps

module cfe_checker #(
    parameter [31:0] RELOAD_CYC = 200,
    parameter [31:0] PRE_CYC    = 100
) (
    input wire        mclk,
    input wire        rst,
    input wire        window_in,
    input wire        msd_zero_in,
    input wire        s_axi_awvalid,
    input wire        s_axi_wvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire [11:0] err_count,
    input wire        err_negative,
    input wire        readout_blank,
    input wire        freq_error_fault
);

    // All checks live in the one clock domain.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Gate fall as seen after the input synchronisers have settled.
    sequence s_fall_seen;
        $fell(window_in) ##6 1'b1;
    endsequence

    property p_reload_tail;
        s_fall_seen |-> readout_blank [*8];
    endproperty
    a_reload_tail: assert property (p_reload_tail)
        else $error("readout not blanked after gate fall");

    property p_blank_mask;
        readout_blank && $past(readout_blank) |-> !freq_error_fault;
    endproperty
    a_blank_mask: assert property (p_blank_mask)
        else $error("fault shown while blanked");

    property p_fault_rise;
        $rose(freq_error_fault) |-> !readout_blank;
    endproperty
    a_fault_rise: assert property (p_fault_rise)
        else $error("fault rose during blanking");

    property p_unkeyed;
        msd_zero_in [*5] |-> err_count == 12'h000;
    endproperty
    a_unkeyed: assert property (p_unkeyed)
        else $error("error count not held clear while unkeyed");

    property p_sign_closed;
        $rose(err_negative) |-> !window_in && !$past(window_in, 4);
    endproperty
    a_sign_closed: assert property (p_sign_closed)
        else $error("negative sign while gate open");

    property p_err_clear;
        $rose(readout_blank) |-> err_count < 12'h002;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("error count not cleared at blank start");

    property p_aw_answer;
        s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
            |=> s_axi_awready && s_axi_wready && s_axi_bvalid;
    endproperty
    a_aw_answer: assert property (p_aw_answer)
        else $error("write not answered next cycle");

    property p_ar_answer;
        s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
            |=> s_axi_arready && s_axi_rvalid;
    endproperty
    a_ar_answer: assert property (p_ar_answer)
        else $error("read not answered next cycle");

    property p_aw_pulse;
        s_axi_awready |=> !s_axi_awready;
    endproperty
    a_aw_pulse: assert property (p_aw_pulse)
        else $error("awready longer than one cycle");

endmodule // cfe_checker

bind cfe_channel_freq_error cfe_checker #(
    .RELOAD_CYC(RELOAD_CYC), .PRE_CYC(PRE_CYC)) u_chk (
    .mclk(mclk), .rst(rst), .window_in(window_in),
    .msd_zero_in(msd_zero_in), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .err_count(err_count),
    .err_negative(err_negative), .readout_blank(readout_blank),
    .freq_error_fault(freq_error_fault));

/* dv/tb_top.sv */
// Self-checking bench for the channel frequency error counter.
`timescale 1ns/1ps
`include "cfe_map.vh"

`define CFE_CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
    fails++; $display("mismatch %s expected %h seen %h", nm, exp, got); end end

module tb_top;

    reg         mclk;
    reg         rst;
    reg  [3:0]  awaddr;
    reg  [3:0]  araddr;
    reg  [31:0] wdata;
    reg         awvalid;
    reg         wvalid;
    reg         bready;
    reg         arvalid;
    reg         rready;
    wire        awready;
    wire        wready;
    wire        bvalid;
    wire        arready;
    wire        rvalid;
    wire [1:0]  bresp;
    wire [1:0]  rresp;
    wire [31:0] rdata;
    wire        window_in;
    wire        tx_pulse_in;
    wire        msd_zero_in;
    wire [23:0] cmd_bcd;
    wire [11:0] err_count;
    wire        err_negative;
    wire        readout_blank;
    wire        freq_error_fault;
    reg  [31:0] rd_val;
    reg  [1:0]  resp;
    integer     fails;
    integer     n_checks;

    cfe_channel_freq_error #(.RELOAD_CYC(200), .PRE_CYC(100)) u_dut (
        .mclk(mclk), .rst(rst), .window_in(window_in),
        .tx_pulse_in(tx_pulse_in), .msd_zero_in(msd_zero_in),
        .cmd_bcd(cmd_bcd), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .err_count(err_count),
        .err_negative(err_negative), .readout_blank(readout_blank),
        .freq_error_fault(freq_error_fault));

    cfe_far_model u_far (
        .mclk(mclk), .window_in(window_in), .tx_pulse_in(tx_pulse_in),
        .msd_zero_in(msd_zero_in), .cmd_bcd(cmd_bcd));

    // The 200 MHz system clock.
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Prints the verdict; shared by the main sequence and the watchdog.
    task report_and_stop;
        begin
            if (fails == 0 && n_checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    // Write one word; both channels stay offered until each is taken.
    task wr(input [3:0] a, input [31:0] d);
        reg     taken;
        reg     done;
        begin
            taken = 1'b0;
            done = 1'b0;
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            while (!done) begin
                @(posedge mclk);
                if (awready) begin
                    awvalid <= 1'b0;
                    taken = 1'b1;
                end
                if (wready) wvalid <= 1'b0;
                if (bvalid) begin
                    resp = bresp;
                    bready <= 1'b0;
                    done = 1'b1;
                end
            end
            `CFE_CHK("write taken", 1'b1, taken)
            `CFE_CHK("bresp", `CFE_RESP_OKAY, resp)
        end
    endtask

    // Read one word into rd_val.
    task rd(input [3:0] a);
        reg     done;
        begin
            done = 1'b0;
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            while (!done) begin
                @(posedge mclk);
                if (arready) arvalid <= 1'b0;
                if (rvalid) begin
                    rd_val = rdata;
                    resp = rresp;
                    rready <= 1'b0;
                    done = 1'b1;
                end
            end
            `CFE_CHK("rresp", `CFE_RESP_OKAY, resp)
        end
    endtask

    // A hang is cut short well after the expected run of some 2550 cycles.
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        report_and_stop;
    end

    // Main sequence: dummy gate, high gate, low gate, unkeyed, audio.
    initial begin
        rst = 1'b1;
        {awaddr, araddr, wdata} = 40'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        fails = 0;
        n_checks = 0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(`CFE_OFS_CTRL);
        `CFE_CHK("ctrl reset", `CFE_CTRL_RESET, rd_val[0])
        @(posedge mclk);
        rd(`CFE_OFS_THRESH);
        `CFE_CHK("thresh reset", `CFE_THRESH_RESET, rd_val[11:0])
        wr(`CFE_OFS_THRESH, 32'h00000002);
        u_far.measure(24'h000005, 1'b0);
        repeat (250) @(posedge mclk);
        rd(`CFE_OFS_CMD);
        `CFE_CHK("preload", 24'h000005, rd_val[23:0])
        u_far.measure(24'h000010, 1'b0);
        repeat (30) @(posedge mclk);
        `CFE_CHK("blank after fall", 1'b1, readout_blank)
        `CFE_CHK("fault masked", 1'b0, freq_error_fault)
        rd(`CFE_OFS_STATUS);
        `CFE_CHK("fault flag", 1'b1, rd_val[`CFE_ST_FAULT_BIT])
        `CFE_CHK("low flag high", 1'b0, rd_val[`CFE_ST_LOW_BIT])
        repeat (220) @(posedge mclk);
        `CFE_CHK("positive count", 12'h002, err_count)
        `CFE_CHK("positive sign", 1'b0, err_negative)
        `CFE_CHK("blank end", 1'b0, readout_blank)
        `CFE_CHK("fault shown", 1'b1, freq_error_fault)
        wr(`CFE_OFS_THRESH, 32'h00000004);
        u_far.measure(24'h000005, 1'b0);
        repeat (30) @(posedge mclk);
        rd(`CFE_OFS_STATUS);
        `CFE_CHK("low flag low", 1'b1, rd_val[`CFE_ST_LOW_BIT])
        repeat (40) @(posedge mclk);
        `CFE_CHK("negative sign", 1'b1, err_negative)
        repeat (100) @(posedge mclk);
        `CFE_CHK("negative count", 12'h003, err_count)
        repeat (100) @(posedge mclk);
        `CFE_CHK("blank end low", 1'b0, readout_blank)
        `CFE_CHK("fault cleared", 1'b0, freq_error_fault)
        `CFE_CHK("sign expired", 1'b0, err_negative)
        u_far.measure(24'h000005, 1'b1);
        repeat (250) @(posedge mclk);
        `CFE_CHK("unkeyed count", 12'h000, err_count)
        wr(`CFE_OFS_CTRL, 32'h00000001);
        repeat (4) @(posedge mclk);
        `CFE_CHK("audio blank", 1'b1, readout_blank)
        wr(`CFE_OFS_CTRL, 32'h00000000);
        repeat (4) @(posedge mclk);
        `CFE_CHK("rf unblank", 1'b0, readout_blank)
        report_and_stop;
    end

endmodule // tb_top
